// ### logic/synth_freq_power_config.sv
// frequency word, calibration, core power and power table logic
`timescale 1ns/1ps
`include "synth_cfg_defs.svh"
module synth_freq_power_config #(
    parameter int CAL_CYCLES = 18815
) (
    input  wire logic                     core_clk_in,
    input  wire logic                     sys_rst_in,
    input  synth_cfg_pkg::freq_cfg_t      freq_cfg_in,
    input  synth_cfg_pkg::power_cfg_t     power_cfg_in,
    input  wire logic [1:0]               auto_cal_select_in,
    input  wire logic [5:0]               pin_output_select_in,
    input  wire logic                     calibrate_strobe_in,
    input  wire logic                     synth_on_in,
    input  wire logic                     synth_off_in,
    input  wire logic                     sleep_strobe_in,
    input  wire logic                     power_down_strobe_in,
    input  wire logic                     chip_select_n_in,
    input  wire logic                     vco_lock_in,
    output logic      [31:0]              synth_word_out,
    output logic      [14:0]              if_word_out,
    output logic      [7:0]               tx_power_out,
    output logic      [5:0]               synth_cal_result_out,
    output logic                          lock_detect_out,
    output logic                          general_output_pin_out,
    output logic                          core_power_out,
    output logic                          serial_out_low_out,
    output logic                          cal_busy_out,
    output logic                          idle_out
);
    import synth_cfg_pkg::*;

    if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal_cycles
        $error("CAL_CYCLES out of range");
    end

    // spacing in quarter steps: (256 + mantissa) * 2^exp, divided after the product
    function automatic logic [31:0] channel_number_step(input logic [7:0] m, input logic [1:0] e);
        logic [11:0] scaled;
        scaled = 12'({3'b000, (`SPACING_BASE + {1'b0, m})}) << e;
        return {20'h0, scaled};
    endfunction : channel_number_step

    radio_state_t state_q, state_d;
    logic [15:0]  cal_cnt_q;
    logic [7:0]   table_q [2];
    logic [5:0]   cal_res_q;
    logic [2:0]   cs_sync_q, lock_sync_q;
    logic         cs_n_q, lock_q, pd_armed_q, powered_q;
    logic         return_idle_q;

    wire [23:0] base_word = {freq_cfg_in.base_freq_high, freq_cfg_in.base_freq_mid,
                             freq_cfg_in.base_freq_low};
    wire [31:0] step     = channel_number_step(freq_cfg_in.channel_number_spacing_mantissa,
                                     freq_cfg_in.channel_number_spacing_exponent);
    // quarter dropped only after the multiply so fractional steps accumulate
    wire [31:0] product  = 32'((step * {24'h0, freq_cfg_in.channel_number}) >> 2);
    wire [31:0] word_d   = {8'h00, base_word} + product;
    wire        cs_n_new = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_n_q;
    wire        lock_new = (lock_sync_q[1] == lock_sync_q[2]) ? lock_sync_q[2] : lock_q;
    wire        cal_done = (state_q == ST_CAL) && (cal_cnt_q == 16'd1);
    wire        man_cal  = calibrate_strobe_in && (state_q == ST_IDLE);
    wire        start_cal_on = synth_on_in && (state_q == ST_IDLE)
                               && (auto_cal_select_in == `AUTOCAL_ON_START);
    wire        stop_cal = synth_off_in && (state_q == ST_RUN)
                               && (auto_cal_select_in == `AUTOCAL_ON_STOP);
    wire        go_cal   = man_cal || start_cal_on || stop_cal;
    wire        pin_sel  = (pin_output_select_in == `LOCK_SELECT_CODE);
    wire        locked   = (cal_res_q != `CAL_FAIL_VALUE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go_cal) state_d = ST_CAL;
                else if (synth_on_in) state_d = ST_RUN;
                else if (sleep_strobe_in) state_d = ST_SLEEP;
            end
            ST_CAL: begin
                if (cal_done) state_d = return_idle_q ? ST_IDLE : ST_RUN;
            end
            ST_RUN: begin
                if (stop_cal) state_d = ST_CAL;
                else if (synth_off_in) state_d = ST_IDLE;
            end
            ST_SLEEP: begin
                if (!cs_n_q) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // remember what started the calibration to choose the exit state
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q       <= ST_IDLE;
            return_idle_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (go_cal) return_idle_q <= man_cal || stop_cal;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_cnt_q <= 16'h0;
            cal_res_q <= `CAL_FAIL_VALUE;
        end else begin
            if (go_cal) cal_cnt_q <= 16'(CAL_CYCLES);
            else if (cal_cnt_q != 16'h0) cal_cnt_q <= cal_cnt_q - 16'd1;
            // result kept through sleep, only new calibration changes it
            if (cal_done) cal_res_q <= lock_new ? 6'h20 : `CAL_FAIL_VALUE;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_sync_q   <= 3'b111;
            lock_sync_q <= 3'b000;
            cs_n_q      <= 1'b1;
            lock_q      <= 1'b0;
        end else begin
            cs_sync_q   <= {cs_sync_q[1:0], chip_select_n_in};
            lock_sync_q <= {lock_sync_q[1:0], vco_lock_in};
            cs_n_q      <= cs_n_new;
            lock_q      <= lock_new;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pd_armed_q <= 1'b0;
            powered_q  <= 1'b1;
        end else begin
            if (power_down_strobe_in) pd_armed_q <= 1'b1;
            else if (!cs_n_new && !powered_q) pd_armed_q <= 1'b0;
            if (!cs_n_new) powered_q <= 1'b1;
            else if (pd_armed_q) powered_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            table_q[0] <= `POWER_RESET_VALUE;
            table_q[1] <= `POWER_LOST_VALUE;
        end else begin
            if (power_cfg_in.wr_en) table_q[power_cfg_in.wr_idx] <= power_cfg_in.wr_data;
            if (sleep_strobe_in && state_q == ST_IDLE)
                table_q[1] <= `POWER_LOST_VALUE;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            synth_word_out         <= 32'h0;
            if_word_out            <= 15'h0;
            tx_power_out           <= `POWER_RESET_VALUE;
            synth_cal_result_out   <= `CAL_FAIL_VALUE;
            lock_detect_out        <= 1'b0;
            general_output_pin_out <= 1'b0;
            core_power_out         <= 1'b1;
            serial_out_low_out     <= 1'b0;
            cal_busy_out           <= 1'b0;
            idle_out               <= 1'b1;
        end else begin
            synth_word_out         <= word_d;
            if_word_out            <= {freq_cfg_in.if_word, 10'h000};
            tx_power_out           <= table_q[power_cfg_in.power_index_select];
            synth_cal_result_out   <= cal_res_q;
            lock_detect_out        <= lock_new && locked;
            general_output_pin_out <= pin_sel && lock_new && locked;
            core_power_out         <= powered_q;
            serial_out_low_out     <= !cs_n_q && powered_q;
            cal_busy_out           <= (state_d == ST_CAL);
            idle_out               <= (state_d == ST_IDLE);
        end
    end
endmodule : synth_freq_power_config

// ### inc/synth_cfg_defs.svh
// constants for the synthesizer frequency and power configuration block
// Operation
// - base frequency is one 24-bit word
// - synth word adds channel times scaled spacing
// - spacing given as mantissa and exponent
// - IF word scales crystal by 2^-10
// - auto calibration on turn-on or turn-off
// - calibrate strobe in idle starts calibration
// - calibration result survives sleep
// - select code 0x0A routes lock detector
// - result not 0x3F means locked
// - chip select low powers core, output low
// - power-down strobe drops power at deselect
// - two-entry power table, index selects entry
// - on-off keying uses index 1 levels
// - sleep keeps only entry 0
// - entry 0 resets to 0xC6
// - lock shown by rise or steady high
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH
`define SPACING_BASE      9'h100
`define LOCK_SELECT_CODE  6'h0A
`define CAL_FAIL_VALUE    6'h3F
`define POWER_RESET_VALUE 8'hC6
`define POWER_LOST_VALUE  8'h00
`define CAL_TIME_CYCLES   16'd18815
`define AUTOCAL_ON_START  2'd1
`define AUTOCAL_ON_STOP   2'd2
`endif

// ### inc/synth_cfg_pkg.sv
// types for the synthesizer frequency and power configuration block
package synth_cfg_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CAL   = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_SLEEP = 4'b1000
    } radio_state_t;

    typedef struct packed {
        logic [7:0] base_freq_high;
        logic [7:0] base_freq_mid;
        logic [7:0] base_freq_low;
        logic [7:0] channel_number;
        logic [7:0] channel_number_spacing_mantissa;
        logic [1:0] channel_number_spacing_exponent;
        logic [4:0] if_word;
    } freq_cfg_t;

    typedef struct packed {
        logic       wr_en;
        logic       wr_idx;
        logic [7:0] wr_data;
        logic       power_index_select;
    } power_cfg_t;
endpackage : synth_cfg_pkg

// ### verification/host_model.sv
// host pin model: chip select and the wait for the serial output low
`timescale 1ns/1ps
module host_model (
    input  wire logic core_clk_in,
    input  wire logic sel_in,
    input  wire logic so_low_in,
    output logic      chip_select_n_out,
    output logic      ready_out
);
    initial chip_select_n_out = 1'b1;
    always @(negedge core_clk_in) chip_select_n_out <= !sel_in;
    assign ready_out = !chip_select_n_out && so_low_in; // no serial clock before this
endmodule : host_model

// ### verification/synth_freq_power_config_chk.sv
// assertions on the synthesizer configuration block ports
`timescale 1ns/1ps
module synth_freq_power_config_chk
    import synth_cfg_pkg::*;
#(parameter int CAL_CYCLES = 18815) (
    input wire logic core_clk_in, sys_rst_in, calibrate_strobe_in, synth_on_in, synth_off_in,
    input synth_cfg_pkg::freq_cfg_t freq_cfg_in,
    input wire logic [5:0] pin_output_select_in, synth_cal_result_out,
    input wire logic [31:0] synth_word_out,
    input wire logic [14:0] if_word_out,
    input wire logic lock_detect_out, general_output_pin_out, core_power_out,
    input wire logic serial_out_low_out, cal_busy_out, idle_out
);
    logic [31:0] busy_cnt_q;
    wire  [31:0] word_exp = {freq_cfg_in.base_freq_high, freq_cfg_in.base_freq_mid,
        freq_cfg_in.base_freq_low} + ((freq_cfg_in.channel_number * ({23'h0, 1'b1,
        freq_cfg_in.channel_number_spacing_mantissa} << freq_cfg_in.channel_number_spacing_exponent)) >> 2);
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
        if (sys_rst_in) busy_cnt_q <= '0;
        else busy_cnt_q <= cal_busy_out ? busy_cnt_q + 32'h1 : '0;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_word_calc: assert property (##1 synth_word_out == $past(word_exp))
        else $error("synth word wrong");
    a_if_scale: assert property (##1 if_word_out == {$past(freq_cfg_in.if_word), 10'h000})
        else $error("if word wrong");
    a_cal_start: assert property (calibrate_strobe_in && idle_out |=> cal_busy_out)
        else $error("calibration not started");
    a_cal_ignore: assert property (calibrate_strobe_in && !idle_out && !cal_busy_out
        && !synth_on_in && !synth_off_in |=> !cal_busy_out) else $error("strobe not ignored");
    a_cal_length: assert property ($fell(cal_busy_out) |-> busy_cnt_q == CAL_CYCLES)
        else $error("calibration length wrong");
    a_cal_bound: assert property (busy_cnt_q <= CAL_CYCLES) else $error("calibration overrun");
    a_cal_lock: assert property ($fell(cal_busy_out)
        |=> (synth_cal_result_out != 6'h3F) == lock_detect_out) else $error("cal result wrong");
    a_lock_route: assert property (pin_output_select_in == 6'h0A && $past(pin_output_select_in,
        2) == 6'h0A && $stable(lock_detect_out) |-> general_output_pin_out == lock_detect_out)
        else $error("lock not on pin");
    a_serial_power: assert property (serial_out_low_out |-> core_power_out)
        else $error("serial low without power");
    c_cal: cover property ($rose(cal_busy_out));
    c_pd: cover property ($fell(core_power_out));
    c_lock: cover property ($rose(general_output_pin_out));
endmodule : synth_freq_power_config_chk
bind synth_freq_power_config synth_freq_power_config_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.*);

// ### verification/synth_freq_power_config_tb_top.sv
// self-checking bench for the synthesizer configuration block
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module synth_freq_power_config_tb_top;
    import synth_cfg_pkg::*;
    logic clk = 0, rst = 1, cal = 0, on = 0, off = 0, slp = 0, pd = 0, lock = 0, sel = 0;
    freq_cfg_t fc = '0;
    power_cfg_t pc = '0;
    logic [1:0] ac = 0;
    logic [5:0] ps = 0, cres;
    logic cs_n, rdy, gpo, cpw, sol, lkd, busy, idle;
    logic [31:0] sw, v;
    logic [14:0] ifw;
    logic [7:0] txp, e0, e1;
    int err_count = 0, num_checks = 0, k, kq[$];
    logic [31:0] vq[$];
    event look;
    string nm[8] = '{"word", "if", "power", "cal", "pin", "core", "busy", "serial"};
    initial forever #5 clk = ~clk;
    synth_freq_power_config #(.CAL_CYCLES(8)) u_dut (.core_clk_in(clk), .sys_rst_in(rst),
        .freq_cfg_in(fc), .power_cfg_in(pc), .auto_cal_select_in(ac), .pin_output_select_in(ps),
        .calibrate_strobe_in(cal), .synth_on_in(on), .synth_off_in(off), .sleep_strobe_in(slp),
        .power_down_strobe_in(pd), .chip_select_n_in(cs_n), .vco_lock_in(lock),
        .synth_word_out(sw), .if_word_out(ifw), .tx_power_out(txp), .synth_cal_result_out(cres),
        .lock_detect_out(lkd), .general_output_pin_out(gpo), .core_power_out(cpw),
        .serial_out_low_out(sol), .cal_busy_out(busy), .idle_out(idle));
    host_model u_host (.core_clk_in(clk), .sel_in(sel), .so_low_in(sol),
        .chip_select_n_out(cs_n), .ready_out(rdy));
    function automatic logic [31:0] pick(int n);
        logic [31:0] r[8];
        r = '{sw, {17'h0, ifw}, {24'h0, txp}, {26'h0, cres}, {31'h0, gpo}, {31'h0, cpw},
            {31'h0, busy}, {31'h0, sol}};
        return r[n];
    endfunction : pick
    always @(look) while (kq.size() > 0) begin
        k = kq.pop_front();
        v = vq.pop_front();
        `CHK(nm[k], v, pick(k))
    end
    task automatic note(int n, logic [31:0] e);
        kq.push_back(n);
        vq.push_back(e);
        ->look;
    endtask : note
    task automatic step(int n); repeat (n) @(negedge clk); endtask : step
    task automatic pulse(ref logic s); s = 1; step(1); s = 0; endtask : pulse
    task automatic pwr(logic [7:0] d0, logic [7:0] d1); // entry 1 follows entry 0 as one burst
        pc.wr_idx = 0;
        pc.wr_data = d0;
        pc.wr_en = 1;
        step(1);
        pc.wr_idx = 1;
        pc.wr_data = d1;
        step(1);
        pc.wr_en = 0;
    endtask : pwr
    task automatic wait_for(ref logic s, input logic e);
        for (int i = 0; i < 200 && s !== e; i++) step(1);
        if (s !== e) begin
            err_count++;
            $display("mismatch wait exp %b got %b", e, s);
            test_done();
        end
    endtask : wait_for
    task automatic calib(logic l, logic [5:0] e); // after power-on and retuning
        lock = l;
        step(5);
        pulse(cal);
        wait_for(busy, 0);
        step(2);
        note(3, {26'h0, e});
    endtask : calib
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(32'h1628));
        step(16);
        rst = 0;
        step(2);
        note(2, 8'hC6);
        note(3, 6'h3F);
        repeat (4) begin // retuned only in idle
            fc = 47'({$urandom, $urandom});
            step(2);
            note(0, {fc.base_freq_high, fc.base_freq_mid, fc.base_freq_low} + ((fc.channel_number
                * ({23'h0, 1'b1, fc.channel_number_spacing_mantissa} << fc.channel_number_spacing_exponent)) >> 2));
            note(1, {fc.if_word, 10'h000});
        end
        $display("test frequency done");
        e0 = 8'($urandom) & 8'h5F;
        e1 = 8'($urandom) | 8'h80;
        pwr(e0, e1);
        pc.power_index_select = 1;
        step(2);
        note(2, {24'h0, e1});
        pc.power_index_select = 0;
        step(2);
        note(2, {24'h0, e0});
        calib(1, 6'h20);
        calib(0, 6'h3F);
        calib(1, 6'h20);
        ps = 6'h0A;
        step(6);
        note(4, 1);
        lock = 0;
        step(6);
        note(4, 0);
        lock = 1;
        $display("test calibration done");
        pulse(slp);
        step(3);
        sel = 1;
        wait_for(rdy, 1);
        note(7, 1);
        step(4);
        note(2, {24'h0, e0});
        note(3, 6'h20);
        pc.power_index_select = 1;
        step(2);
        note(2, 8'h00);
        pulse(pd);
        sel = 0;
        step(8);
        note(5, 0);
        sel = 1;
        wait_for(cpw, 1);
        note(5, 1);
        $display("test power done");
        pulse(on);
        step(2);
        pulse(cal);
        step(2);
        note(6, 0);
        pulse(off);
        step(2);
        ac = 1;
        pulse(on);
        note(6, 1);
        wait_for(busy, 0);
        pulse(off);
        step(2);
        ac = 2;
        pulse(on);
        step(2);
        pulse(off);
        note(6, 1);
        wait_for(busy, 0);
        $display("test autocal done");
        step(2);
        test_done();
    end
endmodule : synth_freq_power_config_tb_top
